//--- core/wdt_limits.sv
// Limit calculator: upper window and lower boundary in clock cycles
`timescale 1ns/1ns
module wdt_limits (
  input  wire logic                    cap_mode,
  input  wire logic [31:0]             cap_ff,
  input  wire logic                    timeout_select_pin,
  input  wire logic                    ratio_select_pin,
  input  wire wdt_pkg::corner_type     corner,
  output logic [wdt_pkg::CNT_W-1:0]    upper_cyc,
  output logic [wdt_pkg::CNT_W-1:0]    lower_cyc
);

  // ==========================================================
  // Combinational limits; 64-bit arithmetic avoids overflow
  always_comb begin
    logic [63:0] typ;
    logic [63:0] win;
    logic [63:0] rat;
    typ = 64'h0;
    win = 64'h0;
    rat = 64'h1;
    if (cap_mode) begin
      typ = ((64'(cap_ff) + 64'(wdt_pkg::CAP_UNIT_FF)) * 64'(wdt_pkg::CAP_STEP_CYC))
            / 64'(wdt_pkg::CAP_UNIT_FF);
      case (corner)
        wdt_pkg::CORNER_MAX: begin
          win = typ * 64'(wdt_pkg::TOL_MAX_X100) / 64'h64;
          rat = ratio_select_pin ? 64'(wdt_pkg::RAT_CAPW_HIM_X10)
                                 : 64'(wdt_pkg::RAT_CAPW_LOM_X10);
        end
        wdt_pkg::CORNER_MIN: begin
          win = typ * 64'(wdt_pkg::TOL_MIN_X100) / 64'h64;
          rat = ratio_select_pin ? 64'(wdt_pkg::RAT_CAPW_HI_X10)
                                 : 64'(wdt_pkg::RAT_CAPW_LO_X10);
        end
        default: begin
          win = typ;
          rat = ratio_select_pin ? 64'(wdt_pkg::RAT_CAP_HI_X10)
                                 : 64'(wdt_pkg::RAT_CAP_LO_X10);
        end
      endcase
    end else begin
      win = timeout_select_pin ? 64'(wdt_pkg::FIX_LONG_CYC)
                               : 64'(wdt_pkg::FIX_SHORT_CYC);
      if (ratio_select_pin) begin
        rat = timeout_select_pin ? 64'(wdt_pkg::RAT_L_HI_X10)
                                 : 64'(wdt_pkg::RAT_S_HI_X10);
      end else begin
        rat = timeout_select_pin ? 64'(wdt_pkg::RAT_L_LO_X10)
                                 : 64'(wdt_pkg::RAT_S_LO_X10);
      end
    end
    upper_cyc = win[wdt_pkg::CNT_W-1:0];
    lower_cyc = 32'(win * 64'hA / rat);
  end

endmodule : wdt_limits

//--- core/wdt_pkg.sv
// Package: timing constants and modes for the window watchdog
package wdt_pkg;

  // ==========================================================
  // Clock
  localparam int CLK_PERIOD_NS = 100;                 // 10 MHz system clock

  // ==========================================================
  // Fixed timeouts, in microseconds
  localparam int FIX_SHORT_US  = 250000;              // 0.25 s, timeout select low
  localparam int FIX_LONG_US   = 2500000;             // 2.5 s, timeout select high
  // Divide before scaling: the long count would overflow 32 bits otherwise
  localparam int FIX_SHORT_CYC = FIX_SHORT_US / CLK_PERIOD_NS * 1000;
  localparam int FIX_LONG_CYC  = FIX_LONG_US / CLK_PERIOD_NS * 1000;

  // ==========================================================
  // Capacitor-programmed window: (C / 15.55 pF + 1) * 6.25 ms
  localparam int CAP_UNIT_FF   = 15550;               // 15.55 pF in femtofarads
  localparam int CAP_STEP_US   = 6250;                // 6.25 ms
  localparam int CAP_STEP_CYC  = CAP_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int TOL_MAX_X100  = 125;                 // Max window 1.25 x typical
  localparam int TOL_MIN_X100  = 75;                  // Min window 0.75 x typical

  // ==========================================================
  // Lower boundary ratios, times ten
  localparam int RAT_CAP_LO_X10   = 258;              // 1:25.8
  localparam int RAT_CAP_HI_X10   = 645;              // 1:64.5
  localparam int RAT_CAPW_LO_X10  = 287;              // 1:28.7 worst case, min window
  localparam int RAT_CAPW_LOM_X10 = 235;              // 1:23.5 worst case, max window
  localparam int RAT_CAPW_HI_X10  = 927;              // 1:92.7
  localparam int RAT_CAPW_HIM_X10 = 516;              // 1:51.6
  localparam int RAT_S_LO_X10     = 318;              // 1:31.8 short, ratio low
  localparam int RAT_L_LO_X10     = 320;              // 1:32 long, ratio low
  localparam int RAT_S_HI_X10     = 1249;             // 1:124.9 short, ratio high
  localparam int RAT_L_HI_X10     = 1277;             // 1:127.7 long, ratio high

  // ==========================================================
  // Reset delay
  localparam int RST_DELAY_US  = 25000;               // 25 ms
  localparam int RST_DELAY_CYC = RST_DELAY_US * 1000 / CLK_PERIOD_NS;

  localparam int CNT_W = 32;

  // Window corner chosen for a capacitor-programmed part
  typedef enum logic [1:0] {
    CORNER_TYP = 2'b00,
    CORNER_MIN = 2'b01,
    CORNER_MAX = 2'b10
  } corner_type;

  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_FIRST   = 2'b01,
    ST_WINDOW  = 2'b10
  } wd_state_type;

endpackage : wdt_pkg

//--- core/window_watchdog_timing.sv
// Top level: window watchdog with timeout, early trigger and reset delay
//
// What this block does
// - Capacitor window equals (C/15.55pF+1)*6.25ms
// - Capacitor max/min window 1.25x/0.75x typical
// - Ratio low, capacitor: lower boundary window/25.8 typical, window/28.7 min corner, window/23.5 max corner
// - Ratio high, capacitor: lower boundary window/64.5 typical, window/92.7 min corner, window/51.6 max corner
// - Ratio high fixed: 1/124.9 or 1/127.7
// - Ratio low fixed: 1/31.8 or 1/32
// - No capacitor: 0.25 s or 2.5 s
// - Trigger edge recognised on next clock cycle
// - Either trigger edge retriggers the watchdog
// - Missed timeout asserts reset, reinitialises timer
// - First window after reset ignores lower boundary
// - Reset held low about 25 ms
`timescale 1ns/1ns
module window_watchdog_timing (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                watchdog_trigger_input,
  input  wire logic                timeout_select_pin,
  input  wire logic                ratio_select_pin,
  input  wire logic                cap_mode,
  input  wire logic [31:0]         cap_ff,
  input  wire wdt_pkg::corner_type corner,
  output logic                     reset_out_n,
  output logic                     reset_oe_n,
  output logic                     early_violation,
  output logic                     timeout_violation
);

  logic [wdt_pkg::CNT_W-1:0] upper_cyc;
  logic [wdt_pkg::CNT_W-1:0] lower_cyc;

  // ==========================================================
  // Limits from pin straps
  wdt_limits u_limits (
    .cap_mode           (cap_mode),
    .cap_ff             (cap_ff),
    .timeout_select_pin (timeout_select_pin),
    .ratio_select_pin   (ratio_select_pin),
    .corner             (corner),
    .upper_cyc          (upper_cyc),
    .lower_cyc          (lower_cyc)
  );

  // ==========================================================
  // State
  wdt_pkg::wd_state_type     state_r,   state_nxt;
  logic [wdt_pkg::CNT_W-1:0] cnt_r,     cnt_nxt;
  logic                      trig_d_r,  trig_d_nxt;
  logic                      rising_seen_r, rising_seen_nxt;
  logic                      early_r,   early_nxt;
  logic                      tmo_r,     tmo_nxt;

  logic edge_any;
  logic edge_rise;

  // Edge detect against last sampled level; acting next cycle gives slack
  assign edge_any  = watchdog_trigger_input ^ trig_d_r;
  assign edge_rise = watchdog_trigger_input & ~trig_d_r;

  // Next state of the window machine
  always_comb begin
    state_nxt       = state_r;
    cnt_nxt         = cnt_r + 32'h1;
    trig_d_nxt      = watchdog_trigger_input;
    rising_seen_nxt = rising_seen_r;
    early_nxt       = 1'b0;
    tmo_nxt         = 1'b0;
    case (state_r)
      wdt_pkg::ST_HOLD: begin
        // Reset output held low for the delay; trigger ignored meanwhile
        if (cnt_r >= 32'(wdt_pkg::RST_DELAY_CYC - 1)) begin
          state_nxt       = wdt_pkg::ST_FIRST;
          cnt_nxt         = 32'h0;
          rising_seen_nxt = 1'b0;
        end
      end
      wdt_pkg::ST_FIRST, wdt_pkg::ST_WINDOW: begin
        if (edge_any && rising_seen_r && cnt_r < lower_cyc) begin
          state_nxt = wdt_pkg::ST_HOLD;
          cnt_nxt   = 32'h0;
          early_nxt = 1'b1;
        end else if (edge_any) begin
          cnt_nxt = 32'h0;
          // Lower boundary armed only after the first rising edge
          if (edge_rise) begin
            rising_seen_nxt = 1'b1;
            state_nxt       = wdt_pkg::ST_WINDOW;
          end
        end else if (cnt_r >= upper_cyc - 32'h1) begin
          state_nxt = wdt_pkg::ST_HOLD;
          cnt_nxt   = 32'h0;
          tmo_nxt   = 1'b1;
        end
      end
      default: begin
        state_nxt = wdt_pkg::ST_HOLD;
        cnt_nxt   = 32'h0;
      end
    endcase
  end

  // Registers; reset starts in the hold state like power-up
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r       <= wdt_pkg::ST_HOLD;
      cnt_r         <= 32'h0;
      trig_d_r      <= 1'b0;
      rising_seen_r <= 1'b0;
      early_r       <= 1'b0;
      tmo_r         <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      cnt_r         <= cnt_nxt;
      trig_d_r      <= trig_d_nxt;
      rising_seen_r <= rising_seen_nxt;
      early_r       <= early_nxt;
      tmo_r         <= tmo_nxt;
    end
  end

  // ==========================================================
  // Open-drain reset: enable low means pin pulled low
  assign reset_out_n       = 1'b0;
  assign reset_oe_n        = (state_r != wdt_pkg::ST_HOLD);
  assign early_violation   = early_r;
  assign timeout_violation = tmo_r;

endmodule : window_watchdog_timing

//--- tb/tb_top.sv
// Testbench: window watchdog boundaries, timeout and reset hold
`timescale 1ns/1ns
module tb_top;
  logic        sys_clk;
  logic        rst;
  logic        ratio_select_pin;
  logic        timeout_select_pin;
  logic        cap_mode;
  wdt_pkg::corner_type corner;
  logic [31:0] cap_ff;
  logic        trig;
  logic        reset_oe_n;
  logic        early_violation;
  logic        timeout_violation;
  int          error_cnt;
  int          n_tests;
  int          n_early;
  int          cyc;
  int          win;
  // ==========================================================
  // Clock, partner and block
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  trig_host host_u (.sys_clk(sys_clk), .trig(trig));
  window_watchdog_timing dut_u (.sys_clk(sys_clk), .rst(rst), .watchdog_trigger_input(trig),
    .timeout_select_pin(timeout_select_pin), .ratio_select_pin(ratio_select_pin), .cap_mode(cap_mode),
    .cap_ff(cap_ff), .corner(corner), .reset_out_n(), .reset_oe_n(reset_oe_n),
    .early_violation(early_violation), .timeout_violation(timeout_violation));
  // Pulse tally and hang guard; ceiling covers eight holds, six lower tests and one window
  always @(posedge sys_clk) begin
    n_early += (early_violation === 1'b1);
    cyc++;
    if (cyc == 4000000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic check(string nm, int seen, int exp, int tol);
    n_tests++;
    if (!(seen >= exp - tol && seen <= exp + tol)) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic edge_after(int n);
    repeat (n) @(posedge sys_clk);
    host_u.toggle();
  endtask : edge_after
  // Bounded wait for the reset output to let go
  task automatic hold_end();
    int n;
    n = 0;
    while (reset_oe_n !== 1'b1 && n < 260000) begin
      @(posedge sys_clk);
      #10 n++;
    end
    check("hold_cycles", n, wdt_pkg::RST_DELAY_CYC, 5);
  endtask : hold_end
  // ==========================================================
  // Lower boundary: early first edge ignored, late edge kept, early edge caught
  task automatic lower_test(logic mode, logic tsel, logic ratio, wdt_pkg::corner_type crn, int lower);
    int e0;
    #10; // Straps move off the clock edge, while the hold still runs
    cap_mode           = mode;
    timeout_select_pin = tsel;
    ratio_select_pin   = ratio;
    corner             = crn;
    hold_end();
    if (trig) edge_after(5); // A falling edge would not arm the boundary
    e0 = n_early;
    edge_after(100);
    edge_after(lower + 30);
    repeat (4) @(posedge sys_clk);
    check("no_early", n_early - e0, 0, 0);
    edge_after(lower - 30);
    repeat (4) @(posedge sys_clk);
    check("early_seen", n_early - e0, 1, 0);
    check("rst_on_early", reset_oe_n === 1'b0, 1, 0);
    $display("lower boundary test done, mode %0d select %0d ratio %0d", mode, tsel, ratio);
  endtask : lower_test
  // Full window without a trigger, then the reset hold again
  task automatic timeout_test();
    int n;
    #10; // Back to the typical capacitor window, so the expiry is win
    cap_mode           = 1'b1;
    timeout_select_pin = 1'b0;
    ratio_select_pin   = 1'b0;
    corner             = wdt_pkg::CORNER_TYP;
    hold_end();
    edge_after(10);
    n = 0;
    while (timeout_violation !== 1'b1 && n < win + 100) begin
      @(posedge sys_clk);
      #10 n++;
    end
    check("window_cycles", n, win, 3);
    check("rst_on_timeout", reset_oe_n === 1'b0, 1, 0);
    hold_end();
    $display("timeout test done");
  endtask : timeout_test
  initial begin
    rst = 1'b1;
    ratio_select_pin = 1'b0;
    timeout_select_pin = 1'b0;
    cap_mode = 1'b1;
    corner = wdt_pkg::CORNER_TYP;
    cap_ff = 32'h00025F6C; // Ten capacitor units, so the window is exact
    win = (155500 / wdt_pkg::CAP_UNIT_FF + 1) * wdt_pkg::CAP_STEP_CYC;
    repeat (10) @(posedge sys_clk);
    #10 rst = 1'b0;
    lower_test(1'b1, 1'b0, 1'b0, wdt_pkg::CORNER_TYP, win * 10 / wdt_pkg::RAT_CAP_LO_X10);
    lower_test(1'b1, 1'b0, 1'b1, wdt_pkg::CORNER_TYP, win * 10 / wdt_pkg::RAT_CAP_HI_X10);
    // Worst-case corners: window scaled first, then divided by its own ratio
    lower_test(1'b1, 1'b0, 1'b0, wdt_pkg::CORNER_MIN,
      win * wdt_pkg::TOL_MIN_X100 / 100 * 10 / wdt_pkg::RAT_CAPW_LO_X10);
    lower_test(1'b1, 1'b0, 1'b1, wdt_pkg::CORNER_MAX,
      win * wdt_pkg::TOL_MAX_X100 / 100 * 10 / wdt_pkg::RAT_CAPW_HIM_X10);
    // Fixed straps; only the lower boundary fits the run, not the whole window
    lower_test(1'b0, 1'b0, 1'b0, wdt_pkg::CORNER_TYP, wdt_pkg::FIX_SHORT_CYC * 10 / wdt_pkg::RAT_S_LO_X10);
    lower_test(1'b0, 1'b1, 1'b1, wdt_pkg::CORNER_TYP, wdt_pkg::FIX_LONG_CYC * 10 / wdt_pkg::RAT_L_HI_X10);
    timeout_test();
    final_report();
  end
endmodule : tb_top

//--- tb/trig_host.sv
// Partner model: supervised processor that toggles the trigger
`timescale 1ns/1ns
module trig_host (
  input  wire logic sys_clk,
  output logic      trig
);
  // ==========================================================
  // Trigger line, low from power-up as a pulldown would hold it
  initial trig = 1'b0;
  // Edges land just after a clock edge, at points the bench varies
  task automatic toggle();
    @(posedge sys_clk);
    #10 trig = ~trig;
  endtask : toggle
endmodule : trig_host

//--- tb/wdt_monitor.sv
// Checker: relations between trigger, violation pulses and reset output
`timescale 1ns/1ns
module wdt_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic watchdog_trigger_input,
  input wire logic reset_out_n,
  input wire logic reset_oe_n,
  input wire logic early_violation,
  input wire logic timeout_violation
);
  // ==========================================================
  // Low-time counter; the hold is far too long for a repetition
  logic [31:0] low_r;
  logic [31:0] low_nxt;
  always_comb begin
    low_nxt = (rst || reset_oe_n) ? 32'h0 : low_r + 32'h1;
  end
  always_ff @(posedge sys_clk) begin
    low_r <= low_nxt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_early_rst_low: assert property (early_violation |-> !reset_oe_n) else $error("early pulse, reset off");
  a_tmo_rst_low: assert property (timeout_violation |-> !reset_oe_n) else $error("timeout, reset off");
  a_pin_level_low: assert property (reset_out_n == 1'b0) else $error("pin level not low");
  a_hold_length: assert property ($rose(reset_oe_n) |-> low_r >= wdt_pkg::RST_DELAY_CYC - 2 &&
    low_r <= wdt_pkg::RST_DELAY_CYC + 2) else $error("reset hold length wrong");
  a_hold_no_blip: assert property ($fell(reset_oe_n) |=> !reset_oe_n [*8]) else $error("hold too short");
  a_early_single: assert property (early_violation |=> !early_violation) else $error("early pulse long");
  a_hold_quiet: assert property (!reset_oe_n && !$past(reset_oe_n) |-> !early_violation && !timeout_violation)
    else $error("pulse during hold");
  a_early_on_edge: assert property (early_violation |-> $past(watchdog_trigger_input) !=
    $past(watchdog_trigger_input, 2)) else $error("early pulse without edge");
endmodule : wdt_monitor
bind window_watchdog_timing wdt_monitor mon_u (.sys_clk(sys_clk), .rst(rst),
  .watchdog_trigger_input(watchdog_trigger_input), .reset_out_n(reset_out_n), .reset_oe_n(reset_oe_n),
  .early_violation(early_violation), .timeout_violation(timeout_violation));
